// file: logic/rcp_cmd_port.sv
// Added by the designer: the plain strobed port and the register addresses.
module rcp_cmd_port (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire rcp_pkg::rcp_rx_t i_rx,
  output logic o_rx_ready,
  input wire rcp_pkg::rcp_msg_t i_msg,
  output logic [7:0] o_stb,
  output logic o_srq,
  output logic o_remote,
  output logic o_keypad_en,
  output rcp_pkg::rcp_tx_t o_tx,
  input wire logic i_tx_ready,
  input wire rcp_pkg::rcp_rd_t i_rd,
  input wire logic i_stable_a,
  input wire logic i_stable_b,
  input wire logic [rcp_pkg::NUM_W-1:0] i_fs_a,
  input wire logic [rcp_pkg::NUM_W-1:0] i_fs_b,
  output rcp_pkg::rcp_mode_t o_mode_a,
  output rcp_pkg::rcp_mode_t o_mode_b,
  output logic o_active_b,
  output logic signed [rcp_pkg::NUM_W-1:0] o_rate_hi,
  output logic signed [rcp_pkg::NUM_W-1:0] o_rate_lo,
  output logic signed [rcp_pkg::NUM_W-1:0] o_rate_sp,
  output rcp_pkg::rcp_per_t o_rate_per,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd_stb,
  output logic [31:0] o_rdata
);
  import rcp_pkg::*;

  rcp_st_t s, n, p;
  logic [7:0] uc, pcode;
  logic take, term, sep, dig, lett, pop, dok, dnone, fits, ismode, mode_wr;
  logic go_s, go_l;
  logic [1:0] ynv;
  logic [87:0] txt;
  logic [3:0] tl;
  logic [31:0] d;
  logic signed [NUM_W-1:0] val, fs;
  logic [8*REP_N-1:0] rb;
  rcp_rd_t rd;
  rcp_mode_t mv, am;

  // Short text goes first, then CR LF; unused tail stays zero
  function automatic logic [8*REP_N-1:0] short_rep(input logic [87:0] t, input logic [3:0] len);
    logic [8*REP_N-1:0] r;
    r = '0;
    for (int i = 0; i < RD_W; i++) begin
      if (i < int'(len)) r[8*(REP_N-1-i) +: 8] = t[8*(int'(len)-1-i) +: 8];
    end
    r[8*(REP_N-1-int'(len)) +: 8] = CH_CR;
    r[8*(REP_N-2-int'(len)) +: 8] = CH_LF;
    return r;
  endfunction

  function automatic logic [91:0] yn(input logic v);
    return v ? {TX_YES, LEN_YES} : {TX_NO, LEN_NO};
  endfunction

  // {valid, value} for YES/ON and NO/OFF
  function automatic logic [1:0] yn_in(input logic [31:0] v);
    return {v == DS_YES || v == DS_ON || v == DS_NO || v == DS_OFF, v == DS_YES || v == DS_ON};
  endfunction

  assign o_rx_ready = s.ps != PS_SEND;
  assign o_tx.valid = s.ps == PS_SEND;
  assign o_tx.data = s.rep[8*(REP_N-1-int'(s.rptr)) +: 8];

  always_comb begin
    n = s;
    pcode = ERR_NONE;
    pop = 1'b0;
    go_s = 1'b0;
    go_l = 1'b0;
    txt = '0;
    tl = LEN_1;
    rb = '0;
    mode_wr = 1'b0;
    n.rdata = '0;
    uc = (i_rx.data >= CH_LA && i_rx.data <= CH_LZ) ? (i_rx.data & CASE_MASK) : i_rx.data;
    take = i_rx.valid && o_rx_ready;
    sep = uc <= CH_SP && uc != CH_LF;
    dig = uc >= CH_0 && uc <= CH_9;
    lett = uc >= CH_UA && uc <= CH_UZ;
    term = take && (uc == CH_LF || i_rx.eoi);
    rd = s.held ? s.hold : i_rd;
    fs = $signed(s.act ? i_fs_b : i_fs_a);
    am = s.act ? s.mb : s.ma;
    // -----------------------------------
    // Register port
    // -----------------------------------
    if (i_wr && i_addr == REG_CTRL) begin
      n.linked = i_wdata[CTRL_LINK];
      n.act = i_wdata[CTRL_CHAN];
      if (i_wdata[CTRL_OF +: 3] == OF_1 || i_wdata[CTRL_OF +: 3] == OF_3 ||
          i_wdata[CTRL_OF +: 3] == OF_4) n.of = i_wdata[CTRL_OF +: 3];
    end
    if (i_rd_stb) begin
      case (i_addr)
        REG_STATUS: n.rdata = {19'h0, s.ecnt, 1'b0, s.of, s.held, s.linked, s.act, s.lock,
                               s.remote, s.srq};
        REG_MODES: n.rdata = {26'h0, s.per, s.mb, s.ma};
        REG_CTRL: n.rdata = {25'h0, s.of, 2'h0, s.act, s.linked};
        REG_RATE: n.rdata = {8'h0, s.rsp};
        default: n.rdata = '0;
      endcase
    end
    // -----------------------------------
    // Reply transmit
    // -----------------------------------
    if (s.ps == PS_SEND && i_tx_ready) begin
      n.rptr = s.rptr + 6'h1;
      if (s.rptr == s.rlen - 6'h1) n.ps = PS_KEY;
    end
    // -----------------------------------
    // Character parser
    // -----------------------------------
    if (take && uc != CH_LF) begin
      if (s.ps == PS_KEY) begin
        if (sep) begin
          if (s.klen != 4'h0 || s.kq) n.ps = PS_DATA;
        end else if (s.kq) begin
          n.kbad = 1'b1;
        end else if (uc == CH_Q) begin
          n.kq = 1'b1;
        end else if (s.klen == KEY_MAX) begin
          n.key = KW_BAD;
        end else begin
          n.key = {s.key[55:0], uc};
          n.klen = s.klen + 4'h1;
        end
      end else if (sep) begin
        n.dend = s.dany;
      end else if (uc == CH_COMMA) begin
        if (s.items != 2'h3) n.items = s.items + 2'h1;
        n.dend = 1'b0;
      end else if (s.items == 2'h0) begin
        if (s.dend) n.dbad = 1'b1;
        if (!s.dany) begin
          n.dnum = dig || uc == CH_MINUS || uc == CH_PLUS || uc == CH_DOT;
          n.dneg = uc == CH_MINUS;
        end else if ((uc == CH_MINUS || uc == CH_PLUS) && !s.dfrac) begin
          n.dbad = 1'b1;
        end
        if (dig && !s.dfrac) n.dval = NUM_W'(s.dval * 10 + {4'h0, uc[3:0]});
        if (uc == CH_DOT || uc == CH_E) n.dfrac = 1'b1;
        if (n.dnum && lett && uc != CH_E) n.dbad = 1'b1;
        n.dstr = {s.dstr[23:0], uc};
        if (s.dlen != 4'hF) n.dlen = s.dlen + 4'h1;
        n.dany = 1'b1;
      end
    end
    // -----------------------------------
    // Statement execution
    // -----------------------------------
    p = n;
    val = p.dneg ? -$signed(p.dval) : $signed(p.dval);
    dnone = !p.dany && p.items == 2'h0;
    dok = p.dany && !p.dbad && p.items == 2'h0;
    fits = p.dlen <= DS_MAX;
    d = fits ? p.dstr : '0;
    ynv = yn_in(d);
    ismode = 1'b1;
    case (p.key)
      KW_STANDBY: mv = MODE_STANDBY;
      KW_MEASURE: mv = MODE_MEASURE;
      KW_CONTROL: mv = MODE_CONTROL;
      KW_VENT: mv = MODE_VENT;
      default: begin
        mv = MODE_STANDBY;
        ismode = 1'b0;
      end
    endcase
    if (term) begin
      n.ps = PS_KEY;
      n.key = KW_NONE;
      n.klen = 4'h0;
      n.kq = 1'b0;
      n.kbad = 1'b0;
      n.dstr = '0;
      n.dlen = 4'h0;
      {n.dany, n.dnum, n.dneg, n.dfrac, n.dend, n.dbad} = '0;
      n.items = 2'h0;
      n.dval = '0;
      if (p.klen == 4'h0 && !p.kq) begin
        n.ps = PS_KEY;
      end else if (p.kbad) begin
        pcode = ERR_DATA;
      end else if (p.kq) begin
        if (!dnone) pcode = ERR_QUERY;
        else begin
          go_s = 1'b1;
          case (p.key)
            KW_NONE, KW_OUTFORM: txt[7:0] = CH_0 | {5'h0, s.of};
            KW_A: {txt, tl} = {rd.pa, LEN_RD};
            KW_B: {txt, tl} = {rd.pb, LEN_RD};
            KW_AS: {txt, tl} = yn(i_stable_a);
            KW_BS: {txt, tl} = yn(i_stable_b);
            KW_CHAN: txt[7:0] = CH_UA + {7'h0, s.act};
            KW_LINKED: {txt, tl} = yn(s.linked);
            KW_KEYLOCK: {txt, tl} = yn(s.lock);
            KW_ERROR: begin
              txt[7:0] = CH_0 | (s.ecnt != 3'h0 ? s.eq[0] : ERR_NONE);
              pop = 1'b1;
            end
            default: begin
              if (ismode) {txt, tl} = yn(am == mv);
              else begin
                go_s = 1'b0;
                pcode = ERR_KEY;
              end
            end
          endcase
        end
      end else begin
        case (p.key)
          KW_A, KW_B: begin
            if (dnone) n.act = p.key == KW_B;
            else pcode = ERR_DATA;
          end
          KW_CHAN: begin
            if (dok && (d == DS_A || d == DS_B)) n.act = d == DS_B;
            else pcode = ERR_DATA;
          end
          KW_LINKED: begin
            if (dok && ynv[1]) n.linked = ynv[0];
            else pcode = ERR_DATA;
          end
          KW_KEYLOCK: begin
            if (dok && ynv[1]) n.lock = ynv[0];
            else pcode = ERR_DATA;
          end
          KW_OUTFORM: begin
            if (dok && p.dnum && !p.dfrac && (val == 1 || val == 3 || val == 4))
              n.of = val[2:0];
            else pcode = ERR_DATA;
          end
          KW_RHI: begin
            if (!(dok && p.dnum)) pcode = ERR_DATA;
            else if (val <= fs && val > s.rlo && val >= s.rsp) n.rhi = val;
            else pcode = ERR_RANGE;
          end
          KW_RLO: begin
            if (!(dok && p.dnum)) pcode = ERR_DATA;
            else if (val < s.rhi && val <= s.rsp) n.rlo = val;
            else pcode = ERR_RANGE;
          end
          KW_RSP: begin
            if (!(dok && p.dnum)) pcode = ERR_DATA;
            else if (val >= s.rlo && val <= s.rhi) n.rsp = val;
            else pcode = ERR_RANGE;
          end
          KW_RTIME: begin
            if (dok && d == DS_SEC) n.per = PER_SEC;
            else if (dok && d == DS_MIN) n.per = PER_MIN;
            else if (dok && d == DS_HOUR) n.per = PER_HOUR;
            else pcode = ERR_DATA;
          end
          default: begin
            if (ismode && dnone) begin
              mode_wr = 1'b1;
              if (s.linked) begin
                n.ma = mv;
                n.mb = mv;
              end else if (s.act) n.mb = mv;
              else n.ma = mv;
            end else pcode = ismode ? ERR_DATA : ERR_KEY;
          end
        endcase
      end
    end else if (i_msg.talk && s.ps != PS_SEND) begin
      // Talk addressing with nothing queued sends readings, freeing the trigger latch
      go_l = 1'b1;
      n.held = 1'b0;
      case (s.of)
        OF_3: rb = {rd.pa, CH_COMMA, rd.pb, CH_COMMA, rd.ra, CH_COMMA, rd.rb, CH_CR, CH_LF};
        OF_4: rb = short_rep(s.act ? rd.pb : rd.pa, LEN_RD);
        default: rb = {rd.pa, CH_COMMA, rd.pb, CH_CR, CH_LF, {(8*(REP_N-2*RD_W-3)){1'b0}}};
      endcase
    end
    if (go_s) begin
      n.rep = short_rep(txt, tl);
      n.rlen = {2'h0, tl} + LEN_CRLF;
    end else if (go_l) begin
      n.rep = rb;
      n.rlen = s.of == OF_3 ? 6'(REP_N) : s.of == OF_4 ? {2'h0, LEN_RD} + LEN_CRLF :
               6'(2 * RD_W + 3);
    end
    if (go_s || go_l) begin
      n.ps = PS_SEND;
      n.rptr = 6'h0;
    end
    // -----------------------------------
    // Error queue and service request
    // -----------------------------------
    if (i_msg.spoll) begin
      n.ecnt = 3'h0;
      n.srq = 1'b0;
    end else if (pop && s.ecnt != 3'h0) begin
      n.eq = s.eq >> 8;
      n.ecnt = s.ecnt - 3'h1;
    end
    if (pcode != ERR_NONE) begin
      if (n.ecnt < 3'(EQ_N)) begin
        n.eq[n.ecnt[1:0]] = pcode;
        n.ecnt = n.ecnt + 3'h1;
      end
      n.srq = 1'b1;
    end
    // -----------------------------------
    // Interface messages
    // -----------------------------------
    if (take && i_msg.ren) n.remote = 1'b1;
    if (!i_msg.ren || i_msg.gtl) n.remote = 1'b0;
    if (i_msg.gtl) n.lock = 1'b0;
    if (i_msg.llo) n.lock = 1'b1;
    if (i_msg.get) begin
      n.hold = i_rd;
      n.held = 1'b1;
    end
    if (i_msg.dcl || i_msg.sdc) begin
      // Clear wins over the key, items, reply and errors of this cycle, not over dval, dfrac, dstr or dlen; remote state is left alone
      n.ps = PS_KEY;
      n.key = KW_NONE;
      n.klen = 4'h0;
      {n.kq, n.kbad, n.dany, n.dend, n.dbad, n.held} = '0;
      n.items = 2'h0;
      n.rptr = 6'h0;
      n.ecnt = 3'h0;
      n.srq = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
      s.rhi <= RST_RHI;
      s.of <= OF_1;
    end else begin
      s <= n;
    end
  end

  // No parallel poll or controller logic exists; status byte serves serial poll
  always_comb begin
    o_stb = '0;
    o_stb[STB_RQS] = s.srq;
  end
  assign o_srq = s.srq;
  assign o_remote = s.remote;
  assign o_keypad_en = !s.lock;
  assign o_mode_a = s.ma;
  assign o_mode_b = s.mb;
  assign o_active_b = s.act;
  assign o_rate_hi = s.rhi;
  assign o_rate_lo = s.rlo;
  assign o_rate_sp = s.rsp;
  assign o_rate_per = s.per;
  assign o_rdata = s.rdata;

  // -----------------------------------
  // Assertions
  // -----------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_srq_set;
    pcode != ERR_NONE && !(i_msg.dcl || i_msg.sdc) |=> o_srq && o_stb[STB_RQS];
  endproperty
  a_srq_set: assert property (p_srq_set) else $error("error did not raise srq");
  property p_poll_clr;
    i_msg.spoll && pcode == ERR_NONE |=> !o_srq && s.ecnt == 3'h0;
  endproperty
  a_poll_clr: assert property (p_poll_clr) else $error("poll left srq set");
  property p_llo;
    i_msg.llo |=> !o_keypad_en;
  endproperty
  a_llo: assert property (p_llo) else $error("lockout left keypad on");
  property p_gtl;
    i_msg.gtl && !i_msg.llo |=> !o_remote && o_keypad_en;
  endproperty
  a_gtl: assert property (p_gtl) else $error("go to local not taken");
  property p_dcl;
    (i_msg.dcl || i_msg.sdc) && i_msg.ren && !i_msg.gtl |=>
      s.ecnt == 3'h0 && o_remote == $past(o_remote) && o_rx_ready;
  endproperty
  a_dcl: assert property (p_dcl) else $error("device clear wrong");
  property p_eoi;
    take && i_rx.eoi |=> s.klen == 4'h0 && s.ps != PS_DATA;
  endproperty
  a_eoi: assert property (p_eoi) else $error("eoi did not end statement");
  property p_lf;
    take && i_rx.data == CH_LF |=> s.klen == 4'h0 && !s.kq;
  endproperty
  a_lf: assert property (p_lf) else $error("linefeed did not end statement");
  property p_linked;
    mode_wr && s.linked && !(i_msg.dcl || i_msg.sdc) |=> o_mode_a == o_mode_b;
  endproperty
  a_linked: assert property (p_linked) else $error("linked modes differ");
  property p_unlinked;
    mode_wr && !s.linked && !s.act |=> o_mode_b == $past(o_mode_b);
  endproperty
  a_unlinked: assert property (p_unlinked) else $error("idle channel changed");
  property p_rate;
    o_rate_lo < o_rate_hi && o_rate_sp >= o_rate_lo && o_rate_sp <= o_rate_hi;
  endproperty
  a_rate: assert property (p_rate) else $error("rate limits out of order");
  property p_crlf;
    o_tx.valid && i_tx_ready && s.rptr == s.rlen - 6'h2 |->
      o_tx.data == CH_CR ##1 o_tx.valid && o_tx.data == CH_LF;
  endproperty
  a_crlf: assert property (p_crlf) else $error("reply not ended by CR LF");

  c_linked: cover property (mode_wr && s.linked);
  c_trig_talk: cover property (i_msg.get ##[1:50] i_msg.talk);
  c_err: cover property (pcode != ERR_NONE ##[1:20] pop);
  c_reply: cover property (o_tx.valid && i_tx_ready && s.rptr == s.rlen - 6'h1);
endmodule

// file: logic/rcp_pkg.sv
package rcp_pkg;
  localparam int NUM_W = 24;
  localparam int RD_W = 11;
  localparam int REP_N = 49;
  localparam int EQ_N = 4;
  localparam logic [3:0] KEY_MAX = 4'h8;
  localparam logic [3:0] DS_MAX = 4'h4;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_Q = 8'h3F;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_UA = 8'h41;
  localparam logic [7:0] CH_UZ = 8'h5A;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_MASK = 8'hDF;
  // Keywords, upper case, right-justified
  localparam logic [63:0] KW_NONE = 64'h0;
  localparam logic [63:0] KW_BAD = 64'hFFFFFFFFFFFFFFFF;
  localparam logic [63:0] KW_A = 64'h41;
  localparam logic [63:0] KW_B = 64'h42;
  localparam logic [63:0] KW_AS = 64'h4153;
  localparam logic [63:0] KW_BS = 64'h4253;
  localparam logic [63:0] KW_CHAN = 64'h4348414E;
  localparam logic [63:0] KW_STANDBY = 64'h5354414E444259;
  localparam logic [63:0] KW_MEASURE = 64'h4D454153555245;
  localparam logic [63:0] KW_CONTROL = 64'h434F4E54524F4C;
  localparam logic [63:0] KW_VENT = 64'h56454E54;
  localparam logic [63:0] KW_LINKED = 64'h4C494E4B4544;
  localparam logic [63:0] KW_KEYLOCK = 64'h4B45594C4F434B;
  localparam logic [63:0] KW_OUTFORM = 64'h4F5554464F524D;
  localparam logic [63:0] KW_ERROR = 64'h4552524F52;
  localparam logic [63:0] KW_RHI = 64'h524154454849;
  localparam logic [63:0] KW_RLO = 64'h524154454C4F;
  localparam logic [63:0] KW_RSP = 64'h52415445534554;
  localparam logic [63:0] KW_RTIME = 64'h5254494D45;
  localparam logic [31:0] DS_A = 32'h41;
  localparam logic [31:0] DS_B = 32'h42;
  localparam logic [31:0] DS_YES = 32'h594553;
  localparam logic [31:0] DS_NO = 32'h4E4F;
  localparam logic [31:0] DS_ON = 32'h4F4E;
  localparam logic [31:0] DS_OFF = 32'h4F4646;
  localparam logic [31:0] DS_SEC = 32'h534543;
  localparam logic [31:0] DS_MIN = 32'h4D494E;
  localparam logic [31:0] DS_HOUR = 32'h484F5552;
  localparam logic [87:0] TX_YES = 88'h594553;
  localparam logic [87:0] TX_NO = 88'h4E4F;
  localparam logic [3:0] LEN_YES = 4'h3;
  localparam logic [3:0] LEN_NO = 4'h2;
  localparam logic [3:0] LEN_1 = 4'h1;
  localparam logic [3:0] LEN_RD = 4'hB;
  localparam logic [5:0] LEN_CRLF = 6'h2;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_KEY = 8'h01;
  localparam logic [7:0] ERR_DATA = 8'h02;
  localparam logic [7:0] ERR_RANGE = 8'h03;
  localparam logic [7:0] ERR_QUERY = 8'h04;
  localparam logic [2:0] OF_1 = 3'h1;
  localparam logic [2:0] OF_3 = 3'h3;
  localparam logic [2:0] OF_4 = 3'h4;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODES = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_RATE = 8'h0C;
  localparam int CTRL_LINK = 0;
  localparam int CTRL_CHAN = 1;
  localparam int CTRL_OF = 4;
  localparam int STB_RQS = 6;
  localparam logic signed [NUM_W-1:0] RST_RHI = 24'sh000001;
  typedef enum logic [1:0] {
    PS_KEY = 2'b00, PS_DATA = 2'b01, PS_SEND = 2'b10
  } rcp_ps_t;
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00, MODE_MEASURE = 2'b01, MODE_CONTROL = 2'b10, MODE_VENT = 2'b11
  } rcp_mode_t;
  typedef enum logic [1:0] {
    PER_SEC = 2'b00, PER_MIN = 2'b01, PER_HOUR = 2'b10
  } rcp_per_t;
  typedef struct packed {logic valid; logic eoi; logic [7:0] data;} rcp_rx_t;
  typedef struct packed {logic valid; logic [7:0] data;} rcp_tx_t;
  typedef struct packed {
    logic llo; logic gtl; logic get; logic dcl; logic sdc; logic spoll; logic talk; logic ren;
  } rcp_msg_t;
  typedef struct packed {
    logic [8*RD_W-1:0] pa; logic [8*RD_W-1:0] pb; logic [8*RD_W-1:0] ra; logic [8*RD_W-1:0] rb;
  } rcp_rd_t;
  typedef struct packed {
    rcp_ps_t ps; logic [63:0] key; logic [3:0] klen; logic kq; logic kbad;
    logic [31:0] dstr; logic [3:0] dlen; logic dany; logic dnum; logic dneg; logic dfrac;
    logic dend; logic dbad; logic [1:0] items; logic [NUM_W-1:0] dval;
    logic [8*REP_N-1:0] rep; logic [5:0] rlen; logic [5:0] rptr;
    rcp_mode_t ma; rcp_mode_t mb; logic act; logic linked; logic lock; logic remote;
    logic held; logic [2:0] of; rcp_rd_t hold;
    logic signed [NUM_W-1:0] rhi; logic signed [NUM_W-1:0] rlo; logic signed [NUM_W-1:0] rsp;
    rcp_per_t per; logic [EQ_N-1:0][7:0] eq; logic [2:0] ecnt; logic srq; logic [31:0] rdata;
  } rcp_st_t;
endpackage

// file: tb/rcp_host_model.sv
module rcp_host_model
  import rcp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire rcp_tx_t i_tx,
  input wire logic i_slow,
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] buf_q [0:63];
  int cnt_q;
  logic tog_q;
  // Slow host refuses every other cycle, so reply bytes must hold under stall
  assign o_tx_ready = !(i_slow && tog_q);
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
      tog_q <= 1'b0;
    end else begin
      tog_q <= !tog_q;
      if (i_tx.valid && o_tx_ready) begin
        buf_q[cnt_q[5:0]] <= i_tx.data;
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule

// file: tb/test_remote_ascii_command_port.sv
module test_remote_ascii_command_port;
  timeunit 1ns;
  timeprecision 1ns;
  import rcp_pkg::*;
  logic i_clock = 0, i_nrst = 0, wr = 0, rd = 0, sa = 0, slow = 0, txr, rxr, srq, rem, kp, actb;
  rcp_rx_t rx = '0;
  rcp_msg_t msg = '0;
  rcp_rd_t rdv = '0;
  rcp_tx_t tx;
  rcp_mode_t ma, mb;
  rcp_per_t per;
  logic [7:0] addr = '0, stb;
  logic [31:0] wdata = '0, rdata, v;
  logic signed [NUM_W-1:0] rhi, rlo, rsp;
  int fails = 0, check_count = 0;
  rcp_cmd_port DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_rx(rx), .o_rx_ready(rxr),
    .i_msg(msg), .o_stb(stb), .o_srq(srq), .o_remote(rem), .o_keypad_en(kp), .o_tx(tx),
    .i_tx_ready(txr), .i_rd(rdv), .i_stable_a(sa), .i_stable_b(1'b0), .i_fs_a(24'h000064),
    .i_fs_b(24'h000064), .o_mode_a(ma), .o_mode_b(mb), .o_active_b(actb), .o_rate_hi(rhi),
    .o_rate_lo(rlo), .o_rate_sp(rsp), .o_rate_per(per), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd_stb(rd), .o_rdata(rdata));
  rcp_host_model host (.i_clock(i_clock), .i_nrst(i_nrst), .i_tx(tx), .i_slow(slow),
    .o_tx_ready(txr));
  initial forever #20 i_clock = !i_clock;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic send(string s, bit eoi = 0);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx <= '{valid: 1'b1, eoi: eoi && i == s.len() - 1, data: s[i]};
      n = 0;
      do begin
        @(posedge i_clock);
        n++;
      end while (rxr !== 1'b1 && n < 300);
      if (n >= 300) begin
        fails++;
        end_sim();
      end
    end
    rx <= '0;
    @(posedge i_clock);
  endtask
  task automatic reply(string e);
    int base, n;
    base = host.cnt_q;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while ((tx.valid === 1'b1 || n < 2) && n < 300);
    if (n >= 300) begin
      fails++;
      end_sim();
    end
    chk("reply length", host.cnt_q - base, e.len());
    for (int i = 0; i < e.len(); i++) chk("reply byte", host.buf_q[6'(base + i)], e[i]);
  endtask
  task automatic reg_rd(logic [7:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clock);
    rd <= 1'b0;
    @(posedge i_clock);
    v = rdata;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] dw);
    addr <= a;
    wdata <= dw;
    wr <= 1'b1;
    @(posedge i_clock);
    wr <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic pulse(logic [7:0] m);
    msg <= rcp_msg_t'(msg | m);
    @(posedge i_clock);
    msg <= rcp_msg_t'(msg & ~m);
    @(posedge i_clock);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset;
    reg_rd(REG_STATUS);
    chk("status", v, 32'h00000040);
    reg_rd(8'h30);
    chk("unmapped", v, 32'h00000000);
    chk("keypad", kp, 1'b1);
  endtask
  task automatic s_query;
    slow <= 1'b1;
    sa <= 1'b1;
    send("aS?", 1);
    reply("YES\015\n");
    slow <= 1'b0;
    sa <= 1'b0;
    send("AS?\n");
    reply("NO\015\n");
  endtask
  task automatic s_modes;
    send("linked on\n");
    send("measure\n");
    chk("mode a", ma, MODE_MEASURE);
    chk("mode b", mb, MODE_MEASURE);
    send("LINKED\tNO\n");
    send("Chan  B\n");
    chk("active", actb, 1'b1);
    send("VENT\n");
    chk("mode a", ma, MODE_MEASURE);
    chk("mode b", mb, MODE_VENT);
  endtask
  task automatic s_talk;
    wr_reg(REG_CTRL, 32'h00000032);
    reg_rd(REG_CTRL);
    chk("ctrl", v, 32'h00000032);
    wr_reg(REG_CTRL, 32'h00000072);
    reg_rd(REG_CTRL);
    chk("ctrl refused", v, 32'h00000032);
    rdv <= '{pa: "+1.0000E+01", pb: "+2.0000E+01",
             ra: "+3.0000E+00", rb: "+4.0000E+00"};
    pulse(8'h20);
    rdv.pa <= "-9.0000E+00";
    pulse(8'h02);
    reply("+1.0000E+01,+2.0000E+01,+3.0000E+00,+4.0000E+00\015\n");
    pulse(8'h02);
    reply("-9.0000E+00,+2.0000E+01,+3.0000E+00,+4.0000E+00\015\n");
    send("OUTFORM 4\n");
    pulse(8'h02);
    reply("+2.0000E+01\015\n");
    send("?\n");
    reply("4\015\n");
    send("a?\n");
    reply("-9.0000E+00\015\n");
    send("chan?\n");
    reply("B\015\n");
    send("vent?\n");
    reply("YES\015\n");
  endtask
  task automatic s_err;
    send("BOGUS\n");
    chk("srq", srq, 1'b1);
    chk("stb", stb, 8'h40);
    send("ERROR?\n");
    reply("1\015\n");
    pulse(8'h04);
    chk("srq", srq, 1'b0);
    send("OUTFORM 1,3\n");
    chk("srq", srq, 1'b1);
    pulse(8'h10);
    chk("srq", srq, 1'b0);
    chk("remote", rem, 1'b1);
  endtask
  task automatic s_rate;
    send("RATEHI 5\n");
    send("RATEHI 200\n");
    chk("upper", rhi, 5);
    send("RATESET 3.5e1\n");
    chk("target", rsp, 3);
    send("RATESET 9\n");
    chk("target", rsp, 3);
    send("RATELO 2\n");
    chk("lower", rlo, 2);
    chk("upper", rhi, 5);
    send("RTIME min\n");
    chk("period", per, PER_MIN);
  endtask
  task automatic s_local;
    pulse(8'h80);
    chk("keypad", kp, 1'b0);
    pulse(8'h40);
    chk("keypad", kp, 1'b1);
    chk("remote", rem, 1'b0);
  endtask
  initial begin
    msg.ren = 1'b1;
    repeat (4) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    s_reset();
    s_query();
    s_modes();
    s_talk();
    s_err();
    s_rate();
    s_local();
    end_sim();
  end
endmodule
